// ### rtl/lan_pwr_pkg.sv
// Overview of operation
// - Shutdown needs EEPROM enable plus global power-down.
// - EEPROM read in reset-hold may enter shutdown.
// - Shutdown tri-states every output buffer.
// - Leave shutdown on power-good drop, timed ramp.
// - Host power good: PLL lock, delay, EEPROM read.
// - Shared clock follows both functions; PLL off only in shutdown.
// - Shared resources off only when both ports off.
// - Aux power detect enters reset-hold until power good.
// - Power good loss returns active or D3hot to reset-hold.
// - Reset-hold entry keeps enabled wake filters.
// - Power good rise leaves reset-hold for uninitialized.
// - Power-up EEPROM read may enable magic-packet wake.
// - Power-up with manageability or wake lowers speed.
// - Active to reset-hold with wake lowers speed.
// - Host link stays disabled in power-up reset-hold.
// - Uninitialized entry disables wake, holds PHY reset.
// - Internal power good clears non-sticky state, reloads.
// - Writing 00b leaves D3hot, config space kept.
// - Memory or IO enable write enters active state.
// - Writing 11b enters D3hot, clears enables.
// - D3hot: configuration only, no master cycles.
// - Active keeps magic-packet wake until software clears.
// - Global power-down needs enable, reset-hold, PHY, SerDes.
package lan_pwr_pkg;

	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_RESET_HOLD = 3'h1,
		ST_UNINIT = 3'h2,
		ST_ACTIVE = 3'h3,
		ST_D3HOT = 3'h4,
		ST_SHUTDOWN = 3'h5
	} pwr_state_t;

	typedef enum logic [2:0] {
		PH_IDLE = 3'h0,
		PH_EE_AUX = 3'h1,
		PH_PLL = 3'h2,
		PH_IPG = 3'h3,
		PH_EE_HOST = 3'h4,
		PH_RAMP = 3'h5,
		PH_XOSC = 3'h6,
		PH_EE_EXIT = 3'h7
	} phase_t;

	typedef struct packed {
		logic regulator_shutdown_enable;
		logic reset_hold_pd_enable;
		logic magic_packet_wake;
		logic asf_enable;
	} ee_cfg_t;

	typedef struct packed {
		logic clock_pd;
		logic pll_pd;
		logic res_pd;
	} shared_pd_t;

	localparam int CLK_KHZ = 25000;
	localparam int T_PLL_US = 50;
	localparam int T_IPG_US = 50;
	localparam int T_EE_HOST_MS = 2;
	localparam int T_EE_AUX_MS = 20;
	localparam int T_RAMP_MS = 5;
	localparam int T_XOSC_MS = 10;
	localparam int PLL_CYC = (T_PLL_US * CLK_KHZ + 999) / 1000;
	localparam int IPG_CYC = (T_IPG_US * CLK_KHZ + 999) / 1000;
	localparam int EE_HOST_CYC = T_EE_HOST_MS * CLK_KHZ;
	localparam int EE_AUX_CYC = T_EE_AUX_MS * CLK_KHZ;
	localparam int RAMP_CYC = T_RAMP_MS * CLK_KHZ;
	localparam int XOSC_CYC = T_XOSC_MS * CLK_KHZ;
	localparam int CNT_W = 20;

	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_PMCSR = 8'h04;
	localparam logic [7:0] OFS_COMMAND = 8'h08;
	localparam logic [7:0] OFS_WAKE_CTRL = 8'h0C;
	localparam logic [7:0] OFS_WAKE_FILTER = 8'h10;

	localparam int PM_PME_BIT = 8;
	localparam int CMD_IO_BIT = 0;
	localparam int CMD_MEM_BIT = 1;
	localparam int WUC_MPW_BIT = 0;
	localparam int FILTER_W = 8;
	localparam logic [1:0] PM_D0 = 2'h0;
	localparam logic [1:0] PM_D3 = 2'h3;
	localparam logic [1:0] CMD_RST = 2'h0;
	localparam logic [7:0] FILTER_RST = 8'h00;

endpackage

// ### rtl/lan_power_state_manager.sv
`timescale 1ns/100ps
`default_nettype none
module lan_power_state_manager #(
	parameter int EE_AUX_CYC = lan_pwr_pkg::EE_AUX_CYC,
	parameter int EE_HOST_CYC = lan_pwr_pkg::EE_HOST_CYC,
	parameter int RAMP_CYC = lan_pwr_pkg::RAMP_CYC,
	parameter int XOSC_CYC = lan_pwr_pkg::XOSC_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Asynchronous power pins
	input wire logic aux_power_detect_i,
	input wire logic host_power_good_i,
	// Same-clock status from EEPROM reader, PHY, SerDes and peer function
	input wire lan_pwr_pkg::ee_cfg_t ee_cfg_i,
	input wire logic phy_pd_i,
	input wire logic serdes_pd_i,
	input wire logic peer_pd_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	output logic [31:0] rdata_o,
	// Power control outputs
	output logic [2:0] state_o,
	output logic phy_reset_o,
	output logic wake_enable_o,
	output logic magic_wake_o,
	output logic link_enable_o,
	output logic func_enable_o,
	output logic master_enable_o,
	output logic mem_decode_o,
	output logic low_speed_o,
	output logic out_hiz_o,
	output logic global_pd_o,
	output var lan_pwr_pkg::shared_pd_t shared_pd_o
);

	localparam int CNT_W = lan_pwr_pkg::CNT_W;

	lan_pwr_pkg::pwr_state_t state_q;
	lan_pwr_pkg::phase_t phase_q;
	lan_pwr_pkg::ee_cfg_t cfg_q;
	logic [CNT_W-1:0] cnt_q;
	logic aux_meta_q;
	logic aux_sync_q;
	logic hpg_meta_q;
	logic hpg_sync_q;
	logic hpg_prev_q;
	logic [1:0] cmd_q;
	logic pme_q;
	logic mpw_q;
	logic low_speed_q;
	logic [lan_pwr_pkg::FILTER_W-1:0] filter_q;

	function automatic logic shutdown_ok(input lan_pwr_pkg::ee_cfg_t cfg, input logic phy_pd,
		input logic serdes_pd);
		shutdown_ok = cfg.regulator_shutdown_enable & cfg.reset_hold_pd_enable & phy_pd
			& serdes_pd;
	endfunction

	function automatic logic [CNT_W-1:0] load(input int cycles);
		load = CNT_W'(cycles - 1);
	endfunction

	// Both power pins come from outside the crystal domain.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aux_meta_q <= 1'b0;
			aux_sync_q <= 1'b0;
			hpg_meta_q <= 1'b0;
			hpg_sync_q <= 1'b0;
			hpg_prev_q <= 1'b0;
		end else begin
			aux_meta_q <= aux_power_detect_i;
			aux_sync_q <= aux_meta_q;
			hpg_meta_q <= host_power_good_i;
			hpg_sync_q <= hpg_meta_q;
			hpg_prev_q <= hpg_sync_q;
		end
	end

	wire logic tdone = (cnt_q == '0);
	wire logic pm_wr = we_i && (addr_i == lan_pwr_pkg::OFS_PMCSR);
	wire logic [1:0] pm_field = wdata_i[1:0];
	wire logic in_rh = (state_q == lan_pwr_pkg::ST_RESET_HOLD);
	wire logic in_un = (state_q == lan_pwr_pkg::ST_UNINIT);
	wire logic in_act = (state_q == lan_pwr_pkg::ST_ACTIVE);
	wire logic in_d3 = (state_q == lan_pwr_pkg::ST_D3HOT);
	wire logic in_sd = (state_q == lan_pwr_pkg::ST_SHUTDOWN);
	wire logic live = aux_sync_q && hpg_sync_q;
	wire logic ee_done = tdone && (phase_q == lan_pwr_pkg::PH_EE_AUX
		|| phase_q == lan_pwr_pkg::PH_EE_HOST || phase_q == lan_pwr_pkg::PH_EE_EXIT);
	wire logic aux_done = in_rh && tdone && (phase_q == lan_pwr_pkg::PH_EE_AUX);
	wire logic ipg_event = live && in_rh && tdone && (phase_q == lan_pwr_pkg::PH_IPG);
	wire logic enter_d3 = live && (in_act || in_un) && pm_wr && (pm_field == lan_pwr_pkg::PM_D3);
	wire logic go_active = live && in_un && (phase_q == lan_pwr_pkg::PH_IDLE) && !pm_wr
		&& (cmd_q != lan_pwr_pkg::CMD_RST);
	wire logic global_pd = cfg_q.reset_hold_pd_enable && in_rh && phy_pd_i && serdes_pd_i;
	wire logic wake_armed = mpw_q || pme_q || (filter_q != '0);

	// Power state sequencing: one state register plus a timed phase.
	always_ff @(posedge clk_i) begin
		if (rst_i || !aux_sync_q) begin
			state_q <= lan_pwr_pkg::ST_OFF;
			phase_q <= lan_pwr_pkg::PH_IDLE;
			cnt_q <= '0;
		end else begin
			cnt_q <= tdone ? cnt_q : cnt_q - 1'b1;
			case (state_q)
				lan_pwr_pkg::ST_OFF: begin
					state_q <= lan_pwr_pkg::ST_RESET_HOLD;
					phase_q <= lan_pwr_pkg::PH_EE_AUX;
					cnt_q <= load(EE_AUX_CYC);
				end
				lan_pwr_pkg::ST_RESET_HOLD: begin
					case (phase_q)
						lan_pwr_pkg::PH_IDLE: begin
							// Power good can only be high here after it rose.
							if (hpg_sync_q) begin
								if (shutdown_ok(cfg_q, phy_pd_i, serdes_pd_i)) begin
									state_q <= lan_pwr_pkg::ST_SHUTDOWN;
								end else begin
									phase_q <= lan_pwr_pkg::PH_PLL;
									cnt_q <= load(lan_pwr_pkg::PLL_CYC);
								end
							end
						end
						lan_pwr_pkg::PH_EE_AUX: begin
							if (tdone) begin
								phase_q <= lan_pwr_pkg::PH_IDLE;
								if (!hpg_sync_q && shutdown_ok(ee_cfg_i, phy_pd_i, serdes_pd_i)) begin
									state_q <= lan_pwr_pkg::ST_SHUTDOWN;
								end
							end
						end
						lan_pwr_pkg::PH_PLL: begin
							if (!hpg_sync_q) begin
								phase_q <= lan_pwr_pkg::PH_IDLE;
							end else if (tdone) begin
								phase_q <= lan_pwr_pkg::PH_IPG;
								cnt_q <= load(lan_pwr_pkg::IPG_CYC);
							end
						end
						lan_pwr_pkg::PH_IPG: begin
							if (!hpg_sync_q) begin
								phase_q <= lan_pwr_pkg::PH_IDLE;
							end else if (tdone) begin
								state_q <= lan_pwr_pkg::ST_UNINIT;
								phase_q <= lan_pwr_pkg::PH_EE_HOST;
								cnt_q <= load(EE_HOST_CYC);
							end
						end
						lan_pwr_pkg::PH_RAMP: begin
							if (tdone) begin
								phase_q <= lan_pwr_pkg::PH_XOSC;
								cnt_q <= load(XOSC_CYC);
							end
						end
						lan_pwr_pkg::PH_XOSC: begin
							if (tdone) begin
								phase_q <= lan_pwr_pkg::PH_EE_EXIT;
								cnt_q <= load(EE_HOST_CYC);
							end
						end
						lan_pwr_pkg::PH_EE_EXIT: begin
							if (tdone) begin
								phase_q <= lan_pwr_pkg::PH_IDLE;
							end
						end
						default: begin
							phase_q <= lan_pwr_pkg::PH_IDLE;
						end
					endcase
				end
				lan_pwr_pkg::ST_SHUTDOWN: begin
					// Exit takes a fall of power good, so a read-time entry with it low holds.
					if (hpg_prev_q && !hpg_sync_q) begin
						state_q <= lan_pwr_pkg::ST_RESET_HOLD;
						phase_q <= lan_pwr_pkg::PH_RAMP;
						cnt_q <= load(RAMP_CYC);
					end
				end
				lan_pwr_pkg::ST_UNINIT, lan_pwr_pkg::ST_ACTIVE, lan_pwr_pkg::ST_D3HOT: begin
					if (!hpg_sync_q) begin
						state_q <= lan_pwr_pkg::ST_RESET_HOLD;
						phase_q <= lan_pwr_pkg::PH_IDLE;
					end else if (enter_d3) begin
						state_q <= lan_pwr_pkg::ST_D3HOT;
						phase_q <= lan_pwr_pkg::PH_IDLE;
					end else if (in_d3 && pm_wr && pm_field == lan_pwr_pkg::PM_D0) begin
						state_q <= lan_pwr_pkg::ST_UNINIT;
						phase_q <= lan_pwr_pkg::PH_EE_HOST;
						cnt_q <= load(EE_HOST_CYC);
					end else if (in_un && phase_q == lan_pwr_pkg::PH_EE_HOST && tdone) begin
						phase_q <= lan_pwr_pkg::PH_IDLE;
					end else if (go_active) begin
						state_q <= lan_pwr_pkg::ST_ACTIVE;
					end
				end
				default: begin
					state_q <= lan_pwr_pkg::ST_OFF;
					phase_q <= lan_pwr_pkg::PH_IDLE;
				end
			endcase
		end
	end

	// Command enables: cleared by internal power good and on D3hot entry.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_q <= lan_pwr_pkg::CMD_RST;
		end else if (ipg_event || enter_d3 || !aux_sync_q) begin
			cmd_q <= lan_pwr_pkg::CMD_RST;
		end else if (we_i && addr_i == lan_pwr_pkg::OFS_COMMAND && !in_d3) begin
			cmd_q <= {wdata_i[lan_pwr_pkg::CMD_MEM_BIT], wdata_i[lan_pwr_pkg::CMD_IO_BIT]};
		end
	end

	// PME enable and wake filters are sticky across reset-hold and internal power good.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pme_q <= 1'b0;
			filter_q <= lan_pwr_pkg::FILTER_RST;
		end else begin
			if (pm_wr) begin
				pme_q <= wdata_i[lan_pwr_pkg::PM_PME_BIT];
			end
			if (we_i && addr_i == lan_pwr_pkg::OFS_WAKE_FILTER) begin
				filter_q <= wdata_i[lan_pwr_pkg::FILTER_W-1:0];
			end
		end
	end

	// An EEPROM load that coincides with a software clear still sets the bit.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mpw_q <= 1'b0;
		end else if (ee_done && ee_cfg_i.magic_packet_wake) begin
			mpw_q <= 1'b1;
		end else if (we_i && addr_i == lan_pwr_pkg::OFS_WAKE_CTRL) begin
			mpw_q <= wdata_i[lan_pwr_pkg::WUC_MPW_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_q <= '0;
		end else if (ee_done) begin
			cfg_q <= ee_cfg_i;
		end
	end

	// Lower link speed only matters outside the active state.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_speed_q <= 1'b0;
		end else if (aux_done && (ee_cfg_i.asf_enable || ee_cfg_i.magic_packet_wake)) begin
			low_speed_q <= 1'b1;
		end else if (in_act && aux_sync_q && !hpg_sync_q
			&& (cfg_q.asf_enable || mpw_q || pme_q)) begin
			low_speed_q <= 1'b1;
		end else if (go_active) begin
			low_speed_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= '0;
		end else if (re_i) begin
			case (addr_i)
				lan_pwr_pkg::OFS_STATUS: rdata_o <= {19'h0, global_pd, out_hiz_o, low_speed_q,
					link_enable_o, phy_reset_o, 1'b0, phase_q, 1'b0, state_q};
				lan_pwr_pkg::OFS_PMCSR: rdata_o <= {23'h0, pme_q, 6'h0,
					(in_d3 ? lan_pwr_pkg::PM_D3 : lan_pwr_pkg::PM_D0)};
				lan_pwr_pkg::OFS_COMMAND: rdata_o <= {30'h0, cmd_q};
				lan_pwr_pkg::OFS_WAKE_CTRL: rdata_o <= {31'h0, mpw_q};
				lan_pwr_pkg::OFS_WAKE_FILTER: rdata_o <= {24'h0, filter_q};
				default: rdata_o <= '0;
			endcase
		end else begin
			rdata_o <= '0;
		end
	end

	// Outputs follow the state one cycle later so every pin is a flop.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phy_reset_o <= 1'b1;
			wake_enable_o <= 1'b0;
			magic_wake_o <= 1'b0;
			link_enable_o <= 1'b0;
			func_enable_o <= 1'b0;
			master_enable_o <= 1'b0;
			mem_decode_o <= 1'b0;
			out_hiz_o <= 1'b0;
			global_pd_o <= 1'b0;
			shared_pd_o <= '0;
		end else begin
			phy_reset_o <= (state_q == lan_pwr_pkg::ST_OFF) || in_sd
				|| ((in_rh || in_un) && phase_q != lan_pwr_pkg::PH_IDLE
				&& phase_q != lan_pwr_pkg::PH_PLL && phase_q != lan_pwr_pkg::PH_IPG);
			wake_enable_o <= wake_armed && (in_rh || in_act || in_d3
				|| (in_un && phase_q == lan_pwr_pkg::PH_IDLE));
			magic_wake_o <= mpw_q && !in_sd && !(in_un && phase_q != lan_pwr_pkg::PH_IDLE);
			link_enable_o <= (in_un && phase_q == lan_pwr_pkg::PH_IDLE) || in_act || in_d3;
			func_enable_o <= in_act;
			master_enable_o <= in_act;
			mem_decode_o <= in_act && cmd_q[lan_pwr_pkg::CMD_MEM_BIT];
			out_hiz_o <= in_sd;
			global_pd_o <= global_pd;
			shared_pd_o.res_pd <= !in_un && !in_act && peer_pd_i;
			shared_pd_o.clock_pd <= !in_un && !in_act && peer_pd_i && !wake_armed;
			shared_pd_o.pll_pd <= in_sd;
		end
	end

	assign state_o = state_q;
	assign low_speed_o = low_speed_q;

	property p_shutdown_hiz;
		@(posedge clk_i) disable iff (rst_i)
		in_sd |=> out_hiz_o && phy_reset_o && shared_pd_o.pll_pd;
	endproperty
	a_shutdown_hiz: assert property (p_shutdown_hiz) else $error("shutdown not tri-stated");

	property p_d3_quiet;
		@(posedge clk_i) disable iff (rst_i)
		in_d3 |=> !master_enable_o && !mem_decode_o && !func_enable_o;
	endproperty
	a_d3_quiet: assert property (p_d3_quiet) else $error("master cycles in D3hot");

	property p_d3_entry;
		@(posedge clk_i) disable iff (rst_i)
		(in_act && live && pm_wr && pm_field == lan_pwr_pkg::PM_D3)
			|=> in_d3 && cmd_q == lan_pwr_pkg::CMD_RST;
	endproperty
	a_d3_entry: assert property (p_d3_entry) else $error("D3hot entry wrong");

	property p_pg_drop;
		@(posedge clk_i) disable iff (rst_i)
		((in_act || in_d3) && aux_sync_q && !hpg_sync_q)
			|=> in_rh && phase_q == lan_pwr_pkg::PH_IDLE;
	endproperty
	a_pg_drop: assert property (p_pg_drop) else $error("no reset-hold on power good loss");

	property p_uninit_read;
		@(posedge clk_i) disable iff (rst_i)
		(in_un && phase_q == lan_pwr_pkg::PH_EE_HOST) |=> phy_reset_o && !wake_enable_o;
	endproperty
	a_uninit_read: assert property (p_uninit_read) else $error("PHY free during read");

	property p_legal_state;
		@(posedge clk_i) disable iff (rst_i)
		state_q inside {lan_pwr_pkg::ST_OFF, lan_pwr_pkg::ST_RESET_HOLD, lan_pwr_pkg::ST_UNINIT,
			lan_pwr_pkg::ST_ACTIVE, lan_pwr_pkg::ST_D3HOT, lan_pwr_pkg::ST_SHUTDOWN};
	endproperty
	a_legal_state: assert property (p_legal_state) else $error("illegal power state");

	property p_pll_wait;
		@(posedge clk_i) disable iff (rst_i)
		(in_rh && phase_q == lan_pwr_pkg::PH_IDLE && live
			&& !shutdown_ok(cfg_q, phy_pd_i, serdes_pd_i))
			|=> (in_rh && hpg_sync_q)[*8] |-> !link_enable_o;
	endproperty
	a_pll_wait: assert property (p_pll_wait) else $error("left reset-hold before PLL lock");

	property p_d3_exit;
		@(posedge clk_i) disable iff (rst_i)
		(in_d3 && live && pm_wr && pm_field == lan_pwr_pkg::PM_D0)
			|=> in_un && phase_q == lan_pwr_pkg::PH_EE_HOST && $stable(filter_q)
			&& pme_q == $past(wdata_i[lan_pwr_pkg::PM_PME_BIT]);
	endproperty
	a_d3_exit: assert property (p_d3_exit) else $error("D3hot exit wrong");

	property p_filters_kept;
		@(posedge clk_i) disable iff (rst_i)
		(in_rh && $past(state_q) != lan_pwr_pkg::ST_RESET_HOLD && !$past(we_i))
			|-> filter_q == $past(filter_q);
	endproperty
	a_filters_kept: assert property (p_filters_kept) else $error("wake filters lost");

	property p_active_entry;
		@(posedge clk_i) disable iff (rst_i)
		go_active |=> in_act ##1 func_enable_o && master_enable_o;
	endproperty
	a_active_entry: assert property (p_active_entry) else $error("active entry wrong");

	property p_shared_pd;
		@(posedge clk_i) disable iff (rst_i)
		shared_pd_o.res_pd |-> $past(peer_pd_i) && !func_enable_o;
	endproperty
	a_shared_pd: assert property (p_shared_pd) else $error("shared power-down with port on");

endmodule // lan_power_state_manager
`default_nettype wire

// ### test/host_pm_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_pm_model (
	// Clock
	input wire logic clk_i,
	// Power pins driven by the platform
	output logic aux_power_detect_o,
	output logic host_power_good_o,
	// EEPROM contents and power-down status seen by the block
	output var lan_pwr_pkg::ee_cfg_t ee_cfg_o,
	output logic phy_pd_o,
	output logic serdes_pd_o,
	output logic peer_pd_o,
	// Configuration access port
	output logic [7:0] addr_o,
	output logic [31:0] wdata_o,
	output logic we_o,
	output logic re_o,
	input wire logic [31:0] rdata_i
);
	initial begin
		aux_power_detect_o = 1'b0;
		host_power_good_o = 1'b0;
		ee_cfg_o = 4'h0;
		phy_pd_o = 1'b0;
		serdes_pd_o = 1'b0;
		peer_pd_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 32'h00000000;
		we_o = 1'b0;
		re_o = 1'b0;
	end

	// Released address and data lines toggle, so a stale value is never mistaken for a live one.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		we_o <= 1'b1;
		@(posedge clk_i);
		we_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		re_o <= 1'b1;
		@(posedge clk_i);
		re_o <= 1'b0;
		addr_o <= ~a;
		#1;
		d = rdata_i;
	endtask

	task automatic set_aux(input logic v);
		@(posedge clk_i);
		aux_power_detect_o <= v;
	endtask

	task automatic set_env(input lan_pwr_pkg::ee_cfg_t c, input logic phy, input logic serdes,
		input logic peer);
		ee_cfg_o <= c;
		phy_pd_o <= phy;
		serdes_pd_o <= serdes;
		peer_pd_o <= peer;
	endtask

	task automatic set_pg(input logic v);
		@(posedge clk_i);
		host_power_good_o <= v;
	endtask

	task automatic d3_enter();
		wr(lan_pwr_pkg::OFS_PMCSR, {30'h00000000, lan_pwr_pkg::PM_D3});
	endtask

	task automatic d3_leave();
		wr(lan_pwr_pkg::OFS_PMCSR, {30'h00000000, lan_pwr_pkg::PM_D0});
	endtask

	task automatic decode_on(input int b);
		wr(lan_pwr_pkg::OFS_COMMAND, 32'h00000001 << b);
	endtask
endmodule // host_pm_model
`default_nettype wire

// ### test/test_lan_power_state_manager.sv
`timescale 1ns/100ps
`default_nettype none
module test_lan_power_state_manager;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic aux, pg, we, re, phy_pd, serdes_pd, peer_pd;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, d;
	lan_pwr_pkg::ee_cfg_t ee_cfg;
	lan_pwr_pkg::shared_pd_t sp;
	logic [2:0] state;
	logic phy_rst, wake_en, magic, link_en, func_en, master_en, mem_dec, low_spd, hiz, gpd;
	int n_mismatch = 0;
	int tests_run = 0;

	always #20 clk_i = ~clk_i;

	host_pm_model u_host_pm_model (.clk_i(clk_i), .aux_power_detect_o(aux),
		.host_power_good_o(pg), .ee_cfg_o(ee_cfg), .phy_pd_o(phy_pd),
		.serdes_pd_o(serdes_pd), .peer_pd_o(peer_pd), .addr_o(addr), .wdata_o(wdata),
		.we_o(we), .re_o(re),
		.rdata_i(rdata));

	lan_power_state_manager #(.EE_AUX_CYC(16), .EE_HOST_CYC(16), .RAMP_CYC(16),
		.XOSC_CYC(16)) u_lan_power_state_manager (.clk_i(clk_i), .rst_i(rst_i),
		.aux_power_detect_i(aux), .host_power_good_i(pg), .ee_cfg_i(ee_cfg),
		.phy_pd_i(phy_pd), .serdes_pd_i(serdes_pd), .peer_pd_i(peer_pd), .addr_i(addr),
		.wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata), .state_o(state),
		.phy_reset_o(phy_rst), .wake_enable_o(wake_en), .magic_wake_o(magic),
		.link_enable_o(link_en), .func_enable_o(func_en), .master_enable_o(master_en),
		.mem_decode_o(mem_dec), .low_speed_o(low_spd), .out_hiz_o(hiz), .global_pd_o(gpd),
		.shared_pd_o(sp));

	task automatic results();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wait_state(input logic [2:0] s, input int lim);
		int n;
		n = 0;
		while (state !== s && n < lim) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk(state, s, "state reached");
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	initial begin
		cycles(10);
		rst_i <= 1'b0;
		cycles(1);
		chk(state, lan_pwr_pkg::ST_OFF, "reset state");
		chk(phy_rst, 1'b1, "reset phy");
		chk(hiz, 1'b0, "reset hiz");
		u_host_pm_model.rd(8'hFC, d);
		chk(d, 32'h00000000, "unmapped read");
		// Power-up read arms magic-packet wake and manageability.
		u_host_pm_model.set_env(4'h3, 1'b0, 1'b0, 1'b0);
		u_host_pm_model.set_aux(1'b1);
		wait_state(lan_pwr_pkg::ST_RESET_HOLD, 8);
		cycles(24);
		chk(magic, 1'b1, "magic wake from eeprom");
		chk(low_spd, 1'b1, "low speed at power-up");
		chk(link_en, 1'b0, "link off in reset-hold");
		chk(state, lan_pwr_pkg::ST_RESET_HOLD, "held without power good");
		u_host_pm_model.wr(lan_pwr_pkg::OFS_WAKE_FILTER, 32'h000000A5);
		u_host_pm_model.set_env(4'h0, 1'b0, 1'b0, 1'b1);
		u_host_pm_model.set_pg(1'b1);
		cycles(2400);
		chk(state, lan_pwr_pkg::ST_RESET_HOLD, "pll and delay pending");
		wait_state(lan_pwr_pkg::ST_UNINIT, 200);
		cycles(3);
		chk(phy_rst, 1'b1, "phy reset in read");
		chk(wake_en, 1'b0, "wake off in read");
		cycles(20);
		chk(phy_rst, 1'b0, "phy reset released");
		chk(link_en, 1'b1, "link after reload");
		u_host_pm_model.decode_on(lan_pwr_pkg::CMD_MEM_BIT);
		wait_state(lan_pwr_pkg::ST_ACTIVE, 4);
		cycles(2);
		chk({func_en, master_en, mem_dec}, 32'h00000007, "active enables");
		chk(magic, 1'b1, "magic wake kept");
		chk(sp.pll_pd, 1'b0, "pll running");
		u_host_pm_model.wr(lan_pwr_pkg::OFS_WAKE_CTRL, 32'h00000000);
		cycles(2);
		chk(magic, 1'b0, "magic wake cleared by software");
		u_host_pm_model.d3_enter();
		wait_state(lan_pwr_pkg::ST_D3HOT, 4);
		u_host_pm_model.rd(lan_pwr_pkg::OFS_COMMAND, d);
		chk(d, 32'h00000000, "enables cleared");
		chk({master_en, mem_dec}, 32'h00000000, "no master in d3");
		chk(sp.res_pd, 1'b1, "shared off when both down");
		u_host_pm_model.wr(lan_pwr_pkg::OFS_COMMAND, 32'h00000002);
		u_host_pm_model.rd(lan_pwr_pkg::OFS_COMMAND, d);
		chk(d, 32'h00000000, "command write refused");
		u_host_pm_model.rd(lan_pwr_pkg::OFS_PMCSR, d);
		chk(d[1:0], 32'h00000003, "power state reads d3");
		u_host_pm_model.set_env(4'h0, 1'b0, 1'b0, 1'b0);
		cycles(3);
		chk(sp.res_pd, 1'b0, "shared on while peer up");
		u_host_pm_model.d3_leave();
		wait_state(lan_pwr_pkg::ST_UNINIT, 4);
		u_host_pm_model.rd(lan_pwr_pkg::OFS_WAKE_FILTER, d);
		chk(d, 32'h000000A5, "filters kept over d3");
		u_host_pm_model.decode_on(lan_pwr_pkg::CMD_IO_BIT);
		wait_state(lan_pwr_pkg::ST_ACTIVE, 16);
		u_host_pm_model.wr(lan_pwr_pkg::OFS_PMCSR, 32'h00000100);
		u_host_pm_model.set_pg(1'b0);
		wait_state(lan_pwr_pkg::ST_RESET_HOLD, 6);
		cycles(2);
		chk(low_spd, 1'b1, "low speed with pme");
		u_host_pm_model.rd(lan_pwr_pkg::OFS_WAKE_FILTER, d);
		chk(d, 32'h000000A5, "filters kept in reset-hold");
		// Shutdown configuration with both link halves powered down.
		u_host_pm_model.set_env(4'hC, 1'b1, 1'b1, 1'b0);
		rst_i <= 1'b1;
		cycles(10);
		rst_i <= 1'b0;
		wait_state(lan_pwr_pkg::ST_SHUTDOWN, 60);
		cycles(2);
		chk(hiz, 1'b1, "tri-stated after power-up read");
		u_host_pm_model.set_pg(1'b1);
		cycles(50);
		chk(state, lan_pwr_pkg::ST_SHUTDOWN, "no exit while power good high");
		u_host_pm_model.set_pg(1'b0);
		wait_state(lan_pwr_pkg::ST_RESET_HOLD, 6);
		cycles(38);
		u_host_pm_model.rd(lan_pwr_pkg::OFS_STATUS, d);
		chk(d[6:4], lan_pwr_pkg::PH_EE_EXIT, "exit read after ramp");
		cycles(20);
		u_host_pm_model.rd(lan_pwr_pkg::OFS_STATUS, d);
		chk(d[6:4], lan_pwr_pkg::PH_IDLE, "exit sequence done");
		chk(gpd, 1'b1, "global power-down");
		chk(hiz, 1'b0, "outputs driven after exit");
		u_host_pm_model.set_env(4'hC, 1'b0, 1'b1, 1'b0);
		cycles(3);
		chk(gpd, 1'b0, "no power-down with phy up");
		u_host_pm_model.set_env(4'hC, 1'b1, 1'b1, 1'b0);
		u_host_pm_model.set_pg(1'b1);
		wait_state(lan_pwr_pkg::ST_SHUTDOWN, 8);
		cycles(2);
		chk(hiz, 1'b1, "outputs tri-stated");
		cycles(50);
		chk(state, lan_pwr_pkg::ST_SHUTDOWN, "stays while power good");
		u_host_pm_model.set_pg(1'b0);
		wait_state(lan_pwr_pkg::ST_RESET_HOLD, 6);
		results();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		$display("[FAIL] %0t watchdog expired", $time);
		results();
	end
endmodule // test_lan_power_state_manager
`default_nettype wire
